// ### design/bus_arbiter.sv
// system bus ownership arbiter: hands the external bus to outside masters
// assumes one bus clock, active-high request/grant internally, and that the
// core's own bus sequencer reports busy/done and write buffer state.
`timescale 1ns/1ps
module bus_arbiter (
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        cold_reset_n_i,
   input  wire logic                        low_run_request_n_i,
   input  wire logic                        high_run_request_n_i,
   input  wire logic                        low_snoop_request_n_i,
   input  wire logic                        high_snoop_request_n_i,
   input  wire logic                        owner_active_n_i,
   input  wire logic                        snoop_strobe_n_i,
   input  wire logic                        nonmaskable_int_n_i,
   input  wire logic [bus_arb_pkg::INT_W-1:0] interrupt_lines_n_i,
   input  wire logic                        own_busy_i,
   input  wire logic                        own_last_i,
   input  wire logic                        own_need_i,
   input  wire logic                        wbuf_empty_i,
   input  wire logic                        wbuf_full_i,
   input  wire logic                        doze_i,
   input  wire logic                        halt_i,
   output logic                             low_run_grant_n_o,
   output logic                             high_run_grant_n_o,
   output logic                             low_snoop_grant_n_o,
   output logic                             high_snoop_grant_n_o,
   output logic                             release_request_n_o,
   output logic                             snoop_take_o,
   output logic                             wbuf_drain_o,
   output logic                             stall_o,
   output logic                             own_allow_o,
   output logic                             internal_bus_free_o,
   output logic                             halted_o,
   output logic                             mem_oe_n_o,
   output logic                             cacheable_flag_o,
   output logic                             identifier_flag_o
);
   import bus_arb_pkg::*;

   arb_state_e  state_q, state_d;
   logic [3:0]  grant_q, grant_d;
   logic [3:0]  target_q, target_d;
   logic        rel_q, rel_d;
   logic        halted_q, halted_d;
   logic        steal_q, steal_d;
   logic        snoop_take_q;
   logic        drain_q;
   logic        oe_n_q;
   logic        flag_q;
   logic        allow_q;
   logic        ibus_q;
   logic [3:0]  req;
   logic [3:0]  pick;
   logic        any_req;
   logic        wake;
   logic        free_now;
   logic        snoop_pick;
   logic        run_owned;

   // request vector in priority slots
   assign req[IDX_HSNOOP] = ~high_snoop_request_n_i;
   assign req[IDX_HRUN]   = ~high_run_request_n_i;
   assign req[IDX_LSNOOP] = ~low_snoop_request_n_i;
   assign req[IDX_LRUN]   = ~low_run_request_n_i;

   req_pick u_pick (
      .req_i  (req),
      .pick_o (pick),
      .any_o  (any_req)
   );

   function automatic logic is_snoop(input logic [3:0] g);
      return g[IDX_HSNOOP] | g[IDX_LSNOOP];
   endfunction

   assign wake       = ~nonmaskable_int_n_i | ~(&interrupt_lines_n_i);
   // own bus free now, or the current own transfer ends on this edge
   assign free_now   = ~own_busy_i | own_last_i;
   assign snoop_pick = is_snoop(pick);
   assign run_owned  = (grant_q != GRANT_NONE) & ~is_snoop(grant_q);

   // halt latch: cleared by an external interrupt or by reset or cold reset
   always_comb begin
      halted_d = halted_q;
      if (halt_i) begin
         halted_d = 1'b1;
      end
      if (wake) begin
         halted_d = 1'b0;
      end
   end

   always_comb begin
      state_d  = state_q;
      grant_d  = grant_q;
      target_d = target_q;
      rel_d    = 1'b0;
      steal_d  = steal_q;
      unique case (state_q)
         ST_OWN: begin
            // doze needs no wakeup; the grant follows the sampled request
            if (any_req && !halted_q && free_now && !own_need_i) begin
               target_d = pick;
               if (snoop_pick && !wbuf_empty_i) begin
                  state_d = ST_DRAIN;
               end else begin
                  grant_d = pick;
                  state_d = ST_GRANT;
               end
            end
         end
         ST_DRAIN: begin
            // a higher request arriving while draining retargets the grant
            if (!any_req) begin
               state_d = ST_OWN;
            end else if (wbuf_empty_i) begin
               grant_d = pick;
               state_d = ST_GRANT;
            end else begin
               target_d = pick;
            end
         end
         ST_GRANT: begin
            if (owner_active_n_i && !rel_q && grant_q != target_q) begin
               grant_d = GRANT_NONE;
               state_d = ST_OWN;
            end else if (owner_active_n_i && (rel_q || !any_req)) begin
               grant_d = GRANT_NONE;
               state_d = steal_q ? ST_STEAL : ST_OWN;
            end else if (owner_active_n_i && !(|(req & grant_q)) && !rel_q) begin
               grant_d = GRANT_NONE;
               state_d = ST_OWN;
            end else begin
               // steal on need or full buffer, only in run mode
               if (run_owned && (own_need_i || wbuf_full_i)) begin
                  steal_d = 1'b1;
               end
               if ((pick > grant_q) || (run_owned && (own_need_i || wbuf_full_i))) begin
                  rel_d = 1'b1;
               end
            end
         end
         ST_STEAL: begin
            // own stolen operation runs; hold off all grants until done
            if (!own_need_i && !wbuf_full_i && free_now) begin
               steal_d = 1'b0;
               state_d = ST_RESUME;
            end
         end
         ST_RESUME: begin
            state_d = ST_OWN;
         end
         default: begin
            state_d = ST_OWN;
            grant_d = GRANT_NONE;
         end
      endcase
      if (!cold_reset_n_i) begin
         state_d  = ST_OWN;
         grant_d  = GRANT_NONE;
         rel_d    = 1'b0;
         steal_d  = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q  <= ST_OWN;
         grant_q  <= GRANT_NONE;
         target_q <= GRANT_NONE;
         rel_q    <= 1'b0;
         steal_q  <= 1'b0;
      end else begin
         state_q  <= state_d;
         grant_q  <= grant_d;
         target_q <= target_d;
         rel_q    <= rel_d;
         steal_q  <= steal_d;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         halted_q <= 1'b0;
      end else begin
         halted_q <= cold_reset_n_i ? halted_d : 1'b0;
      end
   end

   // snoop strobe honoured only under snoop-mode ownership
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         snoop_take_q <= 1'b0;
      end else begin
         snoop_take_q <= ~snoop_strobe_n_i & is_snoop(grant_d);
      end
   end

   // memory outputs: any grant tri-states them; no keeper behind them, so a
   // released bus floats unless the board pulls it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         oe_n_q  <= OE_ON;
         flag_q  <= FLAG_REL;
         drain_q <= 1'b0;
         allow_q <= 1'b1;
         ibus_q  <= 1'b0;
      end else begin
         oe_n_q  <= (grant_d != GRANT_NONE) ? OE_OFF : OE_ON;
         flag_q  <= FLAG_REL;
         drain_q <= (state_d == ST_DRAIN);
         allow_q <= (grant_d == GRANT_NONE) && (state_d != ST_DRAIN);
         ibus_q  <= is_snoop(grant_d);
      end
   end

   always_comb begin
      low_run_grant_n_o    = ~grant_q[IDX_LRUN];
      high_run_grant_n_o   = ~grant_q[IDX_HRUN];
      low_snoop_grant_n_o  = ~grant_q[IDX_LSNOOP];
      high_snoop_grant_n_o = ~grant_q[IDX_HSNOOP];
   end

   assign release_request_n_o = ~rel_q;
   assign snoop_take_o        = snoop_take_q;
   assign wbuf_drain_o        = drain_q;
   assign stall_o             = steal_q;
   assign own_allow_o         = allow_q;
   assign internal_bus_free_o = ibus_q;
   assign halted_o            = halted_q;
   assign mem_oe_n_o          = oe_n_q;
   assign cacheable_flag_o    = flag_q;
   assign identifier_flag_o   = flag_q;

   // ---- checks
   property one_grant;
      @(posedge clk_i) disable iff (!rst_n_i) $onehot0(grant_q);
   endproperty
   one_grant_a: assert property (one_grant) else $error("two grants");

   rel_with_grant_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rel_q |-> grant_q != GRANT_NONE) else $error("release without grant");

   no_snoop_steal_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      is_snoop(grant_q) |-> !steal_q && !stall_o) else $error("steal in snoop mode");

   doze_grant_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      doze_i && state_q == ST_OWN && any_req && !halted_q && free_now && !own_need_i
      && wbuf_empty_i && cold_reset_n_i |=> grant_q != GRANT_NONE)
      else $error("no grant in doze");

   halt_blocks_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      halted_q && !wake && grant_q == GRANT_NONE |=> grant_q == GRANT_NONE)
      else $error("grant while halted");

   sequence seen_free;
      owner_active_n_i && rel_q && cold_reset_n_i;
   endsequence
   drop_grant_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state_q == ST_GRANT ##0 seen_free |=> grant_q == GRANT_NONE)
      else $error("grant held after owner left");

   cold_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !cold_reset_n_i |=> grant_q == GRANT_NONE && !rel_q)
      else $error("grant kept in cold reset");

   drain_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(is_snoop(grant_q)) |-> $past(wbuf_empty_i))
      else $error("snoop grant before drain");

   dead_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(grant_q != GRANT_NONE) |-> oe_n_q == OE_OFF)
      else $error("driving in dead cycle");

   prio_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state_q == ST_OWN && grant_d != GRANT_NONE |-> grant_d == pick)
      else $error("wrong priority");

   busy_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      own_busy_i && !own_last_i && grant_q == GRANT_NONE |=> grant_q == GRANT_NONE)
      else $error("grant during own transfer");
endmodule

// ### inc/bus_arb_pkg.sv
// bus ownership arbiter: shared constants, enums and pin rest values
// assumes one bus clock domain; all pins sampled synchronously
package bus_arb_pkg;
   localparam int          ADDR_W       = 36;
   localparam int          DATA_W       = 64;
   localparam int          BE_W         = 8;
   localparam int          INT_W        = 6;
   localparam int          NREQ         = 4;
   // request / grant vector positions, highest priority first
   localparam int          IDX_HSNOOP   = 3;
   localparam int          IDX_HRUN     = 2;
   localparam int          IDX_LSNOOP   = 1;
   localparam int          IDX_LRUN     = 0;
   localparam logic [3:0]  GRANT_NONE   = 4'h0;
   // pin levels while released; OE_ON is the enable level while the core owns the bus
   localparam logic        FLAG_REL     = 1'b1;
   localparam logic        OE_OFF       = 1'b1;
   localparam logic        OE_ON        = 1'b0;

   typedef enum logic [2:0] {
      ST_OWN    = 3'b000,
      ST_DRAIN  = 3'b001,
      ST_GRANT  = 3'b011,
      ST_STEAL  = 3'b010,
      ST_RESUME = 3'b110
   } arb_state_e;

   typedef enum logic [1:0] {
      PM_RUN  = 2'h0,
      PM_DOZE = 2'h1,
      PM_HALT = 2'h2
   } power_mode_e;
endpackage

// ### design/req_pick.sv
// fixed-priority picker over the four request lines
// assumes requests are active-high, already synchronous
`timescale 1ns/1ps
module req_pick (
   input  wire logic [3:0] req_i,
   output logic      [3:0] pick_o,
   output logic            any_o
);
   import bus_arb_pkg::*;

   always_comb begin
      pick_o = GRANT_NONE;
      if (req_i[IDX_HSNOOP]) begin
         pick_o[IDX_HSNOOP] = 1'b1;
      end else if (req_i[IDX_HRUN]) begin
         pick_o[IDX_HRUN] = 1'b1;
      end else if (req_i[IDX_LSNOOP]) begin
         pick_o[IDX_LSNOOP] = 1'b1;
      end else if (req_i[IDX_LRUN]) begin
         pick_o[IDX_LRUN] = 1'b1;
      end
   end

   assign any_o = |req_i;
endmodule

// ### dv/ext_master.sv
// behavioural outside bus master facing the ownership arbiter
// assumes the bench sets want_i and obey_i at rising edges
`timescale 1ns/1ps
module ext_master (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [3:0] want_i,
   input  wire logic       obey_i,
   input  wire logic [3:0] grant_n_i,
   input  wire logic       release_request_n_i,
   output logic      [3:0] req_n_o,
   output logic            owner_active_n_o
);
   logic active_q;

   // request lines idle high, as pulled up when nobody asks
   assign req_n_o = ~want_i;
   // drives only after the dead cycle; an obedient master yields on a release request
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         active_q <= 1'b0;
      end else if (!release_request_n_i && obey_i) begin
         active_q <= 1'b0;
      end else begin
         active_q <= (grant_n_i != 4'hF) && (want_i != 4'h0);
      end
   end
   // dropping its requests drops ownership in the same cycle
   assign owner_active_n_o = ~(active_q && (want_i != 4'h0));
endmodule

// ### dv/system_bus_ownership_arbiter_tb.sv
// self-checking bench for the bus ownership arbiter
// assumes one 100 MHz bus clock and the ext_master partner model
`timescale 1ns/1ps
module system_bus_ownership_arbiter_tb;
   logic       clk_i, rst_n_i, cold_n, strobe_n, nmi_n, busy, last, need;
   logic       wb_empty, wb_full, doze, halt, obey;
   logic [5:0] int_n;
   logic [3:0] want;
   wire logic [3:0] req_n, grant_n;
   wire logic       owner_n, rel_n, take, drain, stall, allow, ibus, halted, oe_n, cach, ident;
   int         fail_count, num_checks, n;

   ext_master partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .want_i(want), .obey_i(obey),
      .grant_n_i(grant_n), .release_request_n_i(rel_n), .req_n_o(req_n),
      .owner_active_n_o(owner_n));
   bus_arbiter DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cold_reset_n_i(cold_n),
      .low_run_request_n_i(req_n[0]), .high_run_request_n_i(req_n[2]),
      .low_snoop_request_n_i(req_n[1]), .high_snoop_request_n_i(req_n[3]),
      .owner_active_n_i(owner_n), .snoop_strobe_n_i(strobe_n), .nonmaskable_int_n_i(nmi_n),
      .interrupt_lines_n_i(int_n), .own_busy_i(busy), .own_last_i(last), .own_need_i(need),
      .wbuf_empty_i(wb_empty), .wbuf_full_i(wb_full), .doze_i(doze), .halt_i(halt),
      .low_run_grant_n_o(grant_n[0]), .high_run_grant_n_o(grant_n[2]),
      .low_snoop_grant_n_o(grant_n[1]), .high_snoop_grant_n_o(grant_n[3]),
      .release_request_n_o(rel_n), .snoop_take_o(take), .wbuf_drain_o(drain),
      .stall_o(stall), .own_allow_o(allow), .internal_bus_free_o(ibus), .halted_o(halted),
      .mem_oe_n_o(oe_n), .cacheable_flag_o(cach), .identifier_flag_o(ident));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      chk4(what, {3'h0, exp}, {3'h0, got});
   endtask

   // bounded wait; a hang ends the run through the report
   task automatic wait_g(input logic [3:0] exp, input int bound);
      n = 0;
      while (grant_n !== exp && n < bound) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (grant_n !== exp) begin
         chk4("grant wait", exp, grant_n);
         final_report();
      end
   endtask

   task automatic wait_rel();
      for (int i = 0; i < 6 && rel_n !== 1'b0; i++) begin
         @(posedge clk_i);
         #1;
      end
      chk1("release request", 1'b0, rel_n);
      if (rel_n !== 1'b0) final_report();
   endtask

   task automatic end_grant();
      @(posedge clk_i);
      want <= 4'h0;
      wait_g(4'hF, 6);
      chk4("drop latency", 4'h1, 4'(n));
      @(posedge clk_i);
      #1;
      chk1("own drive", 1'b0, oe_n);
      @(posedge clk_i);
   endtask

   task automatic t_basic(input int idx);
      @(posedge clk_i);
      want <= 4'h1 << idx;
      doze <= idx[0];
      wait_g(~(4'h1 << idx), 4);
      if (idx[0] == 1'b0) chk4("grant latency", 4'h1, 4'(n));
      chk1("dead cycle oe", 1'b1, oe_n);
      chk1("cacheable", 1'b1, cach);
      chk1("identifier", 1'b1, ident);
      @(posedge clk_i);
      strobe_n <= 1'b0;
      @(posedge clk_i);
      strobe_n <= 1'b1;
      #1;
      chk1("snoop take", idx[0] | (idx == 3), take);
      end_grant();
   endtask

   task automatic t_prio(input logic [3:0] w, input logic [3:0] exp);
      @(posedge clk_i);
      want <= w;
      wait_g(exp, 6);
      end_grant();
   endtask

   task automatic t_busy();
      @(posedge clk_i);
      busy <= 1'b1;
      want <= 4'h1;
      repeat (3) @(posedge clk_i);
      #1;
      chk4("grant while busy", 4'hF, grant_n);
      @(posedge clk_i);
      last <= 1'b1;
      @(posedge clk_i);
      last <= 1'b0;
      busy <= 1'b0;
      #1;
      chk4("grant at finish", 4'hE, grant_n);
      end_grant();
   endtask

   task automatic t_drain();
      @(posedge clk_i);
      wb_empty <= 1'b0;
      want <= 4'h2;
      repeat (3) @(posedge clk_i);
      #1;
      chk4("grant before drain", 4'hF, grant_n);
      chk1("drain", 1'b1, drain);
      @(posedge clk_i);
      wb_empty <= 1'b1;
      wait_g(4'hD, 4);
      @(posedge clk_i);
      need <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk1("internal bus free", 1'b1, ibus);
      chk1("no steal release", 1'b1, rel_n);
      chk1("no steal stall", 1'b0, stall);
      @(posedge clk_i);
      need <= 1'b0;
      end_grant();
   endtask

   task automatic t_steal(input logic full, input logic ob);
      @(posedge clk_i);
      want <= 4'h1;
      obey <= ob;
      wait_g(4'hE, 4);
      repeat (2) @(posedge clk_i);
      if (full) wb_full <= 1'b1;
      else need <= 1'b1;
      wait_rel();
      if (!full) chk1("stall", 1'b1, stall);
      if (!ob) begin
         repeat (5) @(posedge clk_i);
         #1;
         chk4("refused steal", 4'hE, grant_n);
         chk1("core blocked", 1'b0, allow);
         @(posedge clk_i);
         obey <= 1'b1;
      end
      wait_g(4'hF, 4);
      chk1("release dropped", 1'b1, rel_n);
      @(posedge clk_i);
      need <= 1'b0;
      wb_full <= 1'b0;
      wait_g(4'hE, 8);
      end_grant();
   endtask

   task automatic t_preempt();
      @(posedge clk_i);
      want <= 4'h1;
      wait_g(4'hE, 4);
      repeat (2) @(posedge clk_i);
      want <= 4'h5;
      wait_rel();
      @(posedge clk_i);
      want <= 4'h4;
      wait_g(4'hB, 8);
      end_grant();
   endtask

   task automatic t_halt(input int s);
      @(posedge clk_i);
      halt <= 1'b1;
      @(posedge clk_i);
      halt <= 1'b0;
      want <= 4'h1;
      repeat (4) @(posedge clk_i);
      #1;
      chk1("halted", 1'b1, halted);
      chk4("grant in halt", 4'hF, grant_n);
      @(posedge clk_i);
      if (s == 6) nmi_n <= 1'b0;
      else int_n <= ~(6'h01 << s);
      @(posedge clk_i);
      nmi_n <= 1'b1;
      int_n <= 6'h3F;
      wait_g(4'hE, 4);
      end_grant();
   endtask

   task automatic t_cold();
      @(posedge clk_i);
      want <= 4'h1;
      wait_g(4'hE, 4);
      @(posedge clk_i);
      cold_n <= 1'b0;
      want <= 4'h0;
      wait_g(4'hF, 2);
      @(posedge clk_i);
      cold_n <= 1'b1;
      repeat (2) @(posedge clk_i);
   endtask

   initial begin
      {rst_n_i, busy, last, need, wb_full, doze, halt, want} = '0;
      {cold_n, strobe_n, nmi_n, wb_empty, obey} = 5'h1F;
      int_n = 6'h3F;
      fail_count = 0;
      num_checks = 0;
      repeat (8) @(posedge clk_i);
      #1;
      chk4("reset grants", 4'hF, grant_n);
      chk1("reset release", 1'b1, rel_n);
      chk1("reset oe", 1'b0, oe_n);
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 4; i++) t_basic(i);
      t_prio(4'hF, 4'h7);
      t_prio(4'h5, 4'hB);
      t_prio(4'h3, 4'hD);
      t_busy();
      t_drain();
      t_steal(1'b0, 1'b1);
      t_steal(1'b1, 1'b1);
      t_steal(1'b0, 1'b0);
      t_preempt();
      for (int s = 0; s < 7; s++) t_halt(s);
      t_cold();
      final_report();
   end
endmodule
